// ### rtl/sbm_master.sv
// Purpose: two-wire bus master with APB registers and EEPROM loader
// Assumes: pullups on both lines, strap pulled low to enable
// Notes: single master, no clock stretching, no wait states on APB
// Summary of operation
// - interface off by default; detect flag set on detection, write 1 clears
// - strap low routes clock to pin four, data to pin one
// - bus clock near but never above 100 kHz during transfers
// - idle bus: clock line released, no edges
// - standard mode, at most 100 Kb/s, 7-bit slave addresses
// - start: data falls with clock high; stop: data rises clock high
// - data changes only with clock low, stable while clock high
// - bytes of eight bits, each followed by one acknowledge bit
// - receiver acknowledges by holding data low through ack high phase
// - this block is the sole master and starts every transfer
// - byte write: start, address+0, word address, data MSB first, stop
// - missing slave acknowledge sets the error status bit
// - byte read: direction 1, master acks each byte, drives clock
// - doubleword reads only by the loader after host reset
// - after reset with interface detected, load from EEPROM at 1010000b
// - byte at word address 00h is offset reference or FFh end marker
// - references 01h-04h map to four dwords, only loadable bits written
// - after a reference read four bytes MSB first, auto-increment
// - keep reading eight-byte entries until the end marker
// - undefined condition stops load and sets load error flag
// - references assumed ascending; disorder may load wrong registers
// - write to slave address register starts a software transaction
//
// The implementer's own choices: the address map and register access over APB.
module sbm_master
  import sbm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic latch_strap_n,
  input wire logic multifunction_pin_one_i,
  output logic multifunction_pin_one_o,
  output logic multifunction_pin_one_oe,
  input wire logic multifunction_pin_four_i,
  output logic multifunction_pin_four_o,
  output logic multifunction_pin_four_oe,
  output logic [3:0][31:0] loaded_cfg
);
  sbm_state_t s_reg;
  sbm_state_t s_next;
  logic busy;
  logic sda_in;
  logic tick;
  logic byte_end;
  logic nak;
  logic wr_acc;
  logic wr_slave;
  logic [6:0] addr7;
  logic [7:0] rx_byte;
  logic [31:0] new_dword;
  logic [7:0] hcnt;

  assign busy = s_reg.st != S_IDLE;
  assign sda_in = s_reg.sync2[0];
  assign tick = busy && s_reg.qcnt == Q_LAST;
  assign byte_end = tick && s_reg.q == 2'd3 && s_reg.bitn == BIT_ACK;
  assign nak = sda_in;
  assign rx_byte = s_reg.rx[7:0];
  assign new_dword = {s_reg.dword[23:0], rx_byte};
  assign wr_acc = psel && penable && s_reg.pready && pwrite;
  assign wr_slave = wr_acc && paddr == ADDR_SLAVE;
  assign addr7 = s_reg.ld ? EEPROM_SLAVE : s_reg.slave[7:1];

  always_comb begin
    logic step_done;
    logic err;
    logic [7:0] ctrl;
    s_next = s_reg;
    step_done = 1'b0;
    err = 1'b0;
    ctrl = 8'h00;
    // pins cross two flops before any logic looks at them
    s_next.sync1 = {latch_strap_n, multifunction_pin_four_i,
      multifunction_pin_one_i};
    s_next.sync2 = s_reg.sync1;

    // apb slave: decode in setup, answer in access phase
    ctrl[CS_VALID] = s_reg.valid;
    ctrl[CS_ROMERR] = s_reg.romerr;
    ctrl[CS_ACKERR] = s_reg.ackerr;
    ctrl[CS_DETECT] = s_reg.detect;
    ctrl[CS_BUSY] = busy;
    s_next.pready = psel && !penable;
    s_next.pslverr = 1'b0;
    if (psel && !penable) begin
      s_next.prdata = 32'h0000_0000;
      if (paddr == ADDR_DATA) begin
        s_next.prdata = {24'h00_0000, s_reg.data};
      end else if (paddr == ADDR_INDEX) begin
        s_next.prdata = {24'h00_0000, s_reg.index};
      end else if (paddr == ADDR_SLAVE) begin
        s_next.prdata = {24'h00_0000, s_reg.slave};
      end else if (paddr == ADDR_CTRL) begin
        s_next.prdata = {24'h00_0000, ctrl};
      end else if (paddr >= ADDR_LOAD0 && paddr <= ADDR_LOAD3 &&
                   paddr[1:0] == 2'b00) begin
        s_next.prdata = s_reg.lreg[paddr[3:2]];
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
    if (wr_acc) begin
      if (paddr == ADDR_DATA) begin
        s_next.data = pwdata[7:0];
      end
      if (paddr == ADDR_INDEX) begin
        s_next.index = pwdata[7:0];
      end
      if (paddr == ADDR_CTRL) begin
        // write-one-to-clear; events below win the same cycle
        if (pwdata[CS_ROMERR]) begin
          s_next.romerr = 1'b0;
        end
        if (pwdata[CS_ACKERR]) begin
          s_next.ackerr = 1'b0;
        end
        if (pwdata[CS_DETECT]) begin
          s_next.detect = 1'b0;
        end
      end
    end
    // refused while loader or any transfer runs
    if (wr_slave && !busy && s_reg.enabled) begin
      s_next.slave = pwdata[7:0];
      s_next.valid = 1'b0;
      s_next.st = S_START;
      s_next.qcnt = 7'h00;
      s_next.q = 2'd0;
      s_next.scl_oe = 1'b1;
    end

    // strap and idle lines sampled once after reset release
    if (s_reg.settle != SETTLE_LAST) begin
      s_next.settle = s_reg.settle + 2'd1;
    end else if (!s_reg.det_done) begin
      s_next.det_done = 1'b1;
      if (!s_reg.sync2[2] && s_reg.sync2[1] && s_reg.sync2[0]) begin
        s_next.detect = 1'b1;
        s_next.enabled = 1'b1;
        s_next.ld = 1'b1;
        s_next.st = S_START;
        s_next.qcnt = 7'h00;
        s_next.q = 2'd0;
        s_next.scl_oe = 1'b1;
      end
    end

    // bit engine: four quarters per bit, each Q_CYC cycles
    if (busy) begin
      s_next.qcnt = tick ? 7'h00 : s_reg.qcnt + 7'h01;
    end
    if (tick) begin
      s_next.q = s_reg.q + 2'd1;
      unique case (s_reg.q)
        2'd0: begin
          // data moves only in the second low quarter
          if (s_reg.st == S_START || s_reg.st == S_RSTART) begin
            s_next.sda_oe = 1'b0;
          end else if (s_reg.st == S_STOP) begin
            s_next.sda_oe = 1'b1;
          end else begin
            s_next.sda_oe = !s_reg.tx[8];
          end
        end
        2'd1: begin
          s_next.scl_oe = 1'b0;
        end
        2'd2: begin
          if (s_reg.st == S_START || s_reg.st == S_RSTART) begin
            s_next.sda_oe = 1'b1;
          end else if (s_reg.st == S_STOP) begin
            s_next.sda_oe = 1'b0;
          end
        end
        2'd3: begin
          s_next.scl_oe = 1'b1;
          if (s_reg.st == S_START || s_reg.st == S_RSTART ||
              s_reg.st == S_STOP) begin
            step_done = 1'b1;
          end else begin
            s_next.rx = {s_reg.rx[7:0], sda_in};
            s_next.tx = {s_reg.tx[7:0], 1'b1};
            s_next.bitn = s_reg.bitn + 4'h1;
            step_done = s_reg.bitn == BIT_ACK;
          end
        end
      endcase
    end

    if (step_done) begin
      s_next.bitn = 4'h0;
      unique case (s_reg.st)
        S_START: begin
          s_next.st = S_WADDR;
          s_next.tx = {addr7, 1'b0, 1'b1};
        end
        S_WADDR: begin
          err = nak;
          s_next.st = nak ? S_STOP : S_WIDX;
          s_next.tx = {s_reg.ld ? EEPROM_FIRST : s_reg.index, 1'b1};
        end
        S_WIDX: begin
          err = nak;
          if (nak) begin
            s_next.st = S_STOP;
          end else if (s_reg.ld || s_reg.slave[0]) begin
            s_next.st = S_RSTART;
          end else begin
            s_next.st = S_WDATA;
            s_next.tx = {s_reg.data, 1'b1};
          end
        end
        S_WDATA: begin
          err = nak;
          s_next.st = S_STOP;
        end
        S_RSTART: begin
          s_next.st = S_RADDR;
          s_next.tx = {addr7, 1'b1, 1'b1};
        end
        S_RADDR: begin
          err = nak;
          s_next.st = nak ? S_STOP : S_RBYTE;
          s_next.pos = 3'h0;
          s_next.tx = {8'hff, 1'b0};
        end
        S_RBYTE: begin
          s_next.tx = {8'hff, 1'b0};
          if (!s_reg.ld) begin
            s_next.data = rx_byte;
            s_next.valid = 1'b1;
            s_next.st = S_STOP;
          end else if (s_reg.pos == 3'h0) begin
            if (rx_byte == END_OF_LIST_MARKER) begin
              s_next.st = S_STOP;
            end else if (rx_byte >= REF_FIRST && rx_byte <= REF_LAST) begin
              // entries trusted ascending; no order check
              s_next.ref_idx = 2'(rx_byte - REF_FIRST);
              s_next.pos = 3'h1;
            end else begin
              s_next.romerr = 1'b1;
              s_next.st = S_STOP;
            end
          end else begin
            s_next.pos = s_reg.pos == POS_ENTRY_LAST ? 3'h0 :
              s_reg.pos + 3'h1;
            if (s_reg.pos <= POS_DATA_LAST) begin
              s_next.dword = new_dword;
            end
            if (s_reg.pos == POS_DATA_LAST) begin
              s_next.lreg[s_reg.ref_idx] =
                (s_reg.lreg[s_reg.ref_idx] & ~LOAD_MASK[s_reg.ref_idx]) |
                (new_dword & LOAD_MASK[s_reg.ref_idx]);
            end
          end
        end
        S_STOP: begin
          s_next.st = S_IDLE;
          s_next.ld = 1'b0;
        end
        default: begin
          s_next.st = S_IDLE;
        end
      endcase
      if (err) begin
        s_next.ackerr = 1'b1;
        if (s_reg.ld) begin
          s_next.romerr = 1'b1;
        end
      end
      if (s_next.st == S_IDLE) begin
        s_next.scl_oe = 1'b0;
        s_next.sda_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= S_IDLE;
      s_reg.sync1 <= 3'b111;
      s_reg.sync2 <= 3'b111;
      s_reg.lreg <= {4{LOAD_RESET}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign multifunction_pin_one_o = s_reg.pin_lvl;
  assign multifunction_pin_one_oe = s_reg.sda_oe;
  assign multifunction_pin_four_o = s_reg.pin_lvl;
  assign multifunction_pin_four_oe = s_reg.scl_oe;
  assign loaded_cfg = s_reg.lreg;

  // helper: cycles since the clock line last changed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hcnt <= 8'hff;
    end else if (s_next.scl_oe != s_reg.scl_oe) begin
      hcnt <= 8'h00;
    end else if (hcnt != 8'hff) begin
      hcnt <= hcnt + 8'h01;
    end
  end

  sequence q_sda_low_clk_high;
    !s_reg.scl_oe && s_reg.sda_oe;
  endsequence

  sequence q_start_edge;
    !s_reg.scl_oe && !s_reg.sda_oe ##1 q_sda_low_clk_high;
  endsequence

  property p_idle_release;
    @(posedge clk) disable iff (rst)
    s_reg.st == S_IDLE |-> !multifunction_pin_four_oe &&
      !multifunction_pin_one_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("bus lines driven while idle");

  property p_scl_phase;
    @(posedge clk) disable iff (rst)
    $changed(s_reg.scl_oe) |-> $past(hcnt) >= Q_CYC - 1;
  endproperty
  a_scl_phase: assert property (p_scl_phase)
    else $error("clock phase shorter than a quarter bit");

  property p_sda_stable;
    @(posedge clk) disable iff (rst)
    $changed(s_reg.sda_oe) && !s_reg.scl_oe |->
      s_reg.st == S_START || s_reg.st == S_RSTART || s_reg.st == S_STOP;
  endproperty
  a_sda_stable: assert property (p_sda_stable)
    else $error("data changed while clock high");

  property p_start_cond;
    @(posedge clk) disable iff (rst)
    q_start_edge |-> s_reg.st == S_START || s_reg.st == S_RSTART;
  endproperty
  a_start_cond: assert property (p_start_cond)
    else $error("data fell with clock high outside a start");

  property p_detect_clear;
    @(posedge clk) disable iff (rst)
    s_reg.det_done && wr_acc && paddr == ADDR_CTRL && pwdata[CS_DETECT]
      |=> !s_reg.detect;
  endproperty
  a_detect_clear: assert property (p_detect_clear)
    else $error("detect flag not cleared by write of one");

  property p_ack_err;
    @(posedge clk) disable iff (rst)
    byte_end && nak && s_reg.st != S_RBYTE |=> ##[0:2] s_reg.ackerr;
  endproperty
  a_ack_err: assert property (p_ack_err)
    else $error("missing acknowledge not flagged");

  property p_busy_refuse;
    @(posedge clk) disable iff (rst)
    s_reg.ld && wr_slave |=> $stable(s_reg.slave) && (s_reg.ld || !busy);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("software transfer accepted during load");

  property p_sw_start;
    @(posedge clk) disable iff (rst)
    !busy && s_reg.enabled && wr_slave |=> s_reg.st == S_START &&
      !s_reg.ld ##1 s_reg.st == S_START;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("slave address write did not start a transfer");

  property p_eol_stop;
    @(posedge clk) disable iff (rst)
    byte_end && s_reg.ld && s_reg.st == S_RBYTE && s_reg.pos == 3'h0 &&
      rx_byte == END_OF_LIST_MARKER |=> s_reg.st == S_STOP;
  endproperty
  a_eol_stop: assert property (p_eol_stop)
    else $error("end marker did not stop the load");

  property p_load_word;
    @(posedge clk) disable iff (rst)
    byte_end && s_reg.ld && s_reg.st == S_RBYTE &&
      s_reg.pos == POS_DATA_LAST |=>
      (s_reg.lreg[$past(s_reg.ref_idx)] & LOAD_MASK[$past(s_reg.ref_idx)])
      == ($past(new_dword) & LOAD_MASK[$past(s_reg.ref_idx)]);
  endproperty
  a_load_word: assert property (p_load_word)
    else $error("loaded register does not hold the entry data");

  property p_read_ack;
    @(posedge clk) disable iff (rst)
    s_reg.st == S_RBYTE && s_reg.bitn == BIT_ACK && s_reg.q == 2'd2
      |-> s_reg.sda_oe;
  endproperty
  a_read_ack: assert property (p_read_ack)
    else $error("master did not acknowledge a received byte");
endmodule : sbm_master

// ### rtl/sbm_pkg.sv
// Purpose: constants and types of the two-wire bus master and loader
// Assumes: 25 MHz core clock, standard-mode bus timing
// Notes: register offsets are word aligned on the APB
package sbm_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 10000;
  // quarter bit rounded up so the bus never runs above 100 kHz
  localparam int Q_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [6:0] Q_LAST = 7'(Q_CYC - 1);
  localparam int SYNC_SETTLE = 3;
  localparam logic [1:0] SETTLE_LAST = 2'(SYNC_SETTLE);

  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_SLAVE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_LOAD0 = 8'h10;
  localparam logic [7:0] ADDR_LOAD3 = 8'h1c;

  localparam int CS_VALID = 0;
  localparam int CS_ROMERR = 1;
  localparam int CS_ACKERR = 2;
  localparam int CS_DETECT = 3;
  localparam int CS_BUSY = 5;

  localparam logic [6:0] EEPROM_SLAVE = 7'h50;
  localparam logic [7:0] EEPROM_FIRST = 8'h00;
  localparam logic [7:0] END_OF_LIST_MARKER = 8'hff;
  localparam logic [7:0] REF_FIRST = 8'h01;
  localparam logic [7:0] REF_LAST = 8'h04;
  localparam logic [2:0] POS_DATA_LAST = 3'h4;
  localparam logic [2:0] POS_ENTRY_LAST = 3'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
  // loadable bits of the four doubleword targets, entry 3 first
  localparam logic [3:0][31:0] LOAD_MASK = {
    32'h9f4f_a0c0, 32'h0fff_ffff, 32'hed00_c07a, 32'hffff_ffff};

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_WADDR, S_WIDX, S_WDATA,
    S_RSTART, S_RADDR, S_RBYTE, S_STOP
  } sbm_step_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] settle;
    logic det_done;
    logic enabled;
    logic [7:0] data;
    logic [7:0] index;
    logic [7:0] slave;
    logic valid;
    logic romerr;
    logic ackerr;
    logic detect;
    sbm_step_t st;
    logic ld;
    logic [6:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [8:0] tx;
    logic [8:0] rx;
    logic [2:0] pos;
    logic [1:0] ref_idx;
    logic [31:0] dword;
    logic scl_oe;
    logic sda_oe;
    logic pin_lvl;
    logic [3:0][31:0] lreg;
  } sbm_state_t;
endpackage : sbm_pkg

// ### dv/sbm_eeprom_model.sv
// Purpose: behavioural serial EEPROM slave for the bus master bench
// Assumes: open-drain lines resolved by the bench, pull-ups idle high
// Notes: answers at once, never stretches the clock
module sbm_eeprom_model
  import sbm_pkg::*;
(
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act, sel, rd, tx;
  int n;
  int ph;
  initial begin
    {act, sel, rd, tx, sda_pull} = 5'h00;
    sh = 8'h00;
    ptr = 8'h00;
    n = 0;
    ph = 0;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // edges of data with the clock high are framing, never data
  always @(negedge sda) if (scl === 1'b1) begin
    {act, tx, sda_pull} = 3'b100;
    n = 0;
    ph = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    {act, sda_pull} = 2'b00;
  end
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    n++;
  end
  // the model only moves data while the clock is low
  always @(negedge scl) if (act) begin
    if (n == 8 && !tx) begin
      if (ph == 0) begin
        sel = (sh[7:1] == EEPROM_SLAVE);
        rd = sh[0];
      end else if (ph == 1) begin
        ptr = sh;
      end else if (sel) begin
        mem[ptr] = sh;
        ptr++;
      end
      sda_pull = sel;
    end else if (n == 8) begin
      sda_pull = 1'b0;
    end else if (n == 9) begin
      if (tx) ptr++;
      if (ph == 0) tx = sel && rd;
      n = 0;
      ph++;
      sda_pull = tx && !mem[ptr][7];
    end else if (tx) begin
      sda_pull = !mem[ptr][7 - n];
    end
  end
endmodule : sbm_eeprom_model

// ### dv/tb.sv
// Purpose: self-checking bench for the two-wire master and loader
// Assumes: 25 MHz clock, pull-ups on both lines, one EEPROM slave
// Notes: the bus clock comes from the design, so the bench only
//   resolves the wires; two loader entries keep the run short
module tb
  import sbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic err;
    logic [31:0] mask;
    logic [31:0] val;
  } sbm_note_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, strap_n = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, ent0, ent3;
  logic pready, pslverr, one_oe, four_oe, pull, one_o, four_o;
  logic [3:0][31:0] cfg;
  logic [15:0] seed = 16'h0019;
  logic [7:0] b;
  sbm_note_t notes[$];
  sbm_note_t cur;
  int num_errors = 0, checks_done = 0, scl_pulls = 0, pulls0 = 0;
  wire logic sda = !(one_oe || pull);
  wire logic scl = !four_oe;
  always #20 clk = ~clk;
  sbm_master i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .latch_strap_n(strap_n),
    .multifunction_pin_one_i(sda), .multifunction_pin_one_o(one_o),
    .multifunction_pin_one_oe(one_oe), .multifunction_pin_four_i(scl),
    .multifunction_pin_four_o(four_o), .multifunction_pin_four_oe(four_oe),
    .loaded_cfg(cfg));
  sbm_eeprom_model i_mdl (.scl(scl), .sda(sda), .sda_pull(pull));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    if (k >= 20) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic err = 1'b0);
    logic [31:0] q;
    notes.push_back('{err, m, e & m});
    apb(1'b0, a, 32'h0, q);
  endtask : rd
  // polls carry an empty mask so the monitor keeps in step
  task automatic wait_idle();
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      repeat (100) @(posedge clk);
      notes.push_back('{1'b0, 32'h0, 32'h0});
      apb(1'b0, ADDR_CTRL, 32'h0, q);
      k++;
    end while (q[CS_BUSY] !== 1'b0 && k < 1200);
    if (k >= 1200) num_errors++;
  endtask : wait_idle
  task automatic do_reset(input logic strap);
    strap_n <= strap;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : do_reset
  always @(posedge clk) begin
    if (four_oe === 1'b1) scl_pulls++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cur = notes.pop_front();
      if (cur.mask != 0) begin
        check({pslverr, prdata & cur.mask}, {cur.err, cur.val});
      end
    end
  end
  initial begin
    #1;
    repeat (2) begin
      seed = lfsr(seed);
      ent0 = {ent0[15:0], seed};
      seed = lfsr(seed);
      ent3 = {ent3[15:0], seed};
    end
    seed = lfsr(seed);
    b = seed[7:0];
    i_mdl.mem[0] = REF_FIRST;
    i_mdl.mem[8] = REF_LAST;
    i_mdl.mem[16] = END_OF_LIST_MARKER;
    for (int i = 0; i < 4; i++) begin
      i_mdl.mem[1 + i] = ent0[31 - 8 * i -: 8];
      i_mdl.mem[9 + i] = ent3[31 - 8 * i -: 8];
    end
    do_reset(1'b0);
    wait_idle();
    rd(ADDR_CTRL, 32'h08, 32'h0e);
    rd(ADDR_LOAD0, ent0 & LOAD_MASK[0], 32'hffffffff);
    rd(ADDR_LOAD0 + 8'h04, 32'h0, 32'hffffffff);
    rd(ADDR_LOAD0 + 8'h08, 32'h0, 32'hffffffff);
    rd(ADDR_LOAD3, ent3 & LOAD_MASK[3], 32'hffffffff);
    check({1'b0, cfg[3]}, {1'b0, ent3 & LOAD_MASK[3]});
    check({32'h0, four_oe}, 33'h0);
    check({31'h0, one_o, four_o}, 33'h0);
    wr(ADDR_CTRL, 32'h08);
    rd(ADDR_CTRL, 32'h00, 32'h08);
    wr(ADDR_INDEX, 32'h30);
    wr(ADDR_DATA, {24'h0, b});
    wr(ADDR_SLAVE, {24'h0, EEPROM_SLAVE, 1'b0});
    rd(ADDR_CTRL, 32'h20, 32'h20);
    wait_idle();
    check({25'h0, i_mdl.mem[8'h30]}, {25'h0, b});
    rd(ADDR_CTRL, 32'h00, 32'h04);
    wr(ADDR_DATA, 32'h0);
    wr(ADDR_SLAVE, {24'h0, EEPROM_SLAVE, 1'b1});
    wait_idle();
    rd(ADDR_DATA, {24'h0, b}, 32'hff);
    rd(ADDR_CTRL, 32'h01, 32'h05);
    // nobody answers at this address
    wr(ADDR_SLAVE, 32'h44);
    wait_idle();
    rd(ADDR_CTRL, 32'h04, 32'h05);
    wr(ADDR_CTRL, 32'h04);
    rd(ADDR_CTRL, 32'h00, 32'h04);
    rd(8'h40, 32'h0, 32'hffffffff, 1'b1);
    i_mdl.mem[0] = 8'h07;
    do_reset(1'b0);
    wr(ADDR_SLAVE, {24'h0, EEPROM_SLAVE, 1'b0});
    rd(ADDR_CTRL, 32'h20, 32'h20);
    wait_idle();
    rd(ADDR_CTRL, 32'h02, 32'h02);
    check({1'b0, cfg[0]}, 33'h0);
    check({25'h0, i_mdl.mem[0]}, 33'h07);
    do_reset(1'b1);
    pulls0 = scl_pulls;
    wr(ADDR_SLAVE, {24'h0, EEPROM_SLAVE, 1'b0});
    repeat (600) @(posedge clk);
    rd(ADDR_CTRL, 32'h00, 32'h28);
    check(33'(scl_pulls - pulls0), 33'h0);
    tally_and_finish();
  end
  initial begin
    // the loads and transfers need about 77k cycles in all
    repeat (98000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
